// File: pkg/adcpm_consts.vh
`ifndef ADCPM_CONSTS_VH
`define ADCPM_CONSTS_VH

// Sample rate classes
`define ADCPM_FS_48K 3'h0
`define ADCPM_FS_96K 3'h1
`define ADCPM_FS_192K 3'h2
`define ADCPM_FS_384K 3'h3
`define ADCPM_FS_768K 3'h4

// Slot format codes
`define ADCPM_SLOT_NORMAL 2'h0
`define ADCPM_SLOT_128 2'h1
`define ADCPM_SLOT_256 2'h2
`define ADCPM_SLOT_512 2'h3
`define ADCPM_PAIR_BITS 10'h040

// Control bus modes, one-hot
`define ADCPM_CTRL_THREE 3'h1
`define ADCPM_CTRL_TWO 3'h2
`define ADCPM_CTRL_PAR 3'h4

// Decimation filter kinds, one-hot
`define ADCPM_FLT_SHARP 5'h01
`define ADCPM_FLT_SLOW 5'h02
`define ADCPM_FLT_SD_SHARP 5'h04
`define ADCPM_FLT_SD_SLOW 5'h08
`define ADCPM_FLT_SINGLE 5'h10

// Group delays in sample periods
`define ADCPM_GD_SHARP 4'hf
`define ADCPM_GD_SLOW 4'h8
`define ADCPM_GD_SHORT 4'h6
`define ADCPM_GD_384K 4'h7
`define ADCPM_GD_768K 4'h5

// Bitstream oversampling ratios
`define ADCPM_OSR_64 9'h040
`define ADCPM_OSR_128 9'h080
`define ADCPM_OSR_256 9'h100
`define ADCPM_RATE_64 2'h0
`define ADCPM_RATE_128 2'h1

// Serial word layout
`define ADCPM_PAIR_TOP 6'h3f
`define ADCPM_WORD_TOP 6'h1f
`define ADCPM_WORD_LAST 5'h1f
`define ADCPM_MASK24 32'hffffff00

`endif

// File: hw/adcpm_sync.v
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Two-stage synchroniser for pins from outside the clock domain
module adcpm_sync #(
    parameter W = 1
) (
    input wire clk_sys,
    input wire rstn,
    input wire clkEn,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);
    reg [W-1:0] stage1;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            stage1 <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else if (clkEn) begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // adcpm_sync

`default_nettype wire

// File: hw/adcpm_buf.v
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Small word buffer between the converter core and the serialiser
module adcpm_buf #(
    parameter WIDTH = 192,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire clk_sys,
    input wire rstn,
    input wire clkEn,
    input wire inValid,
    output reg inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    wire push;
    wire pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];

    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            inReady <= 1'b0;
        end else if (clkEn) begin
            if (push) begin
                mem[wrPtr] <= inData;
                wrPtr <= (wrPtr == DEPTH - 1) ? {AW{1'b0}} : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == DEPTH - 1) ? {AW{1'b0}} : rdPtr + 1'b1;
            end
            count <= next_count;
            inReady <= (next_count != DEPTH);
        end
    end
endmodule // adcpm_buf

`default_nettype wire

// File: hw/adcpm_top.v
`timescale 1ns/1ns
`default_nettype none
`include "adcpm_consts.vh"

// ============================================================
// Strap decode, filter select and serial output stage
module adcpm_top #(
    parameter LANES = 3,
    parameter WORD_W = 32
) (
    input wire clk_sys,
    input wire rstn,
    input wire clkEn,
    input wire bitstreamModePin,
    input wire ctrlBusSelPin,
    input wire parallelOrTwowireSelect,
    input wire [3:0] sharedCtrlPin,
    input wire rolloffPolarityPin,
    input wire shortDelayPhasePin,
    input wire formatRatePin0,
    input wire formatRatePin1,
    input wire slotFormatSel0,
    input wire slotFormatSel1,
    input wire cascadeSlotIn,
    input wire overflowIn,
    input wire bitClkIn,
    input wire frameSyncIn,
    input wire [2:0] rateClass,
    input wire sampleValid,
    output wire sampleReady,
    input wire [LANES*2*WORD_W-1:0] sampleData,
    output reg [2:0] ctrlMode,
    output reg [3:0] clockModeSel,
    output reg ctrlDataIn,
    output reg ctrlChipSelect,
    output reg ctrlShiftClock,
    output reg [1:0] chipAddr,
    output reg pcmMode,
    output reg slowRolloffSel,
    output reg bitClockPolaritySel,
    output reg shortDelaySel,
    output reg phaseModSel,
    output reg frameFormatSel,
    output reg wordLengthSel,
    output reg [1:0] bitstreamRateSel,
    output reg [8:0] bitstreamOsr,
    output reg [1:0] slotFormatActive,
    output reg [4:0] filterSel,
    output reg [3:0] groupDelay,
    output reg running,
    output reg pcmOut1,
    output reg pcmOut2,
    output reg pcmOut3,
    output reg bsOutL1,
    output reg bsOutR1,
    output reg bsOutR1Oe,
    output reg bsOutR3,
    output reg overflowFlagOut,
    output reg testOut1,
    output reg testOut1Oe,
    output reg testOut2,
    output reg testOut2Oe
);
    localparam PAIR_W = 2 * WORD_W;
    localparam ST_WAIT = 2'b01;
    localparam ST_RUN = 2'b10;

    // ============================================================
    // Pin synchronisers
    wire [16:0] pinRaw;
    wire [16:0] pinSync;
    assign pinRaw = {bitstreamModePin, ctrlBusSelPin, parallelOrTwowireSelect, sharedCtrlPin,
                     rolloffPolarityPin, shortDelayPhasePin, formatRatePin0, formatRatePin1,
                     slotFormatSel1, slotFormatSel0, cascadeSlotIn, overflowIn, bitClkIn, frameSyncIn};

    adcpm_sync #(.W(17)) uSync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clkEn(clkEn),
        .asyncIn(pinRaw),
        .syncOut(pinSync)
    );

    wire sBs = pinSync[16];
    wire sBusSel = pinSync[15];
    wire sPsn = pinSync[14];
    wire [3:0] sShared = pinSync[13:10];
    wire sRolloff = pinSync[9];
    wire sDelay = pinSync[8];
    wire sFmt0 = pinSync[7];
    wire sFmt1 = pinSync[6];
    wire [1:0] sSlot = pinSync[5:4];
    wire sCascade = pinSync[3];
    wire sOvf = pinSync[2];
    wire sBitClk = pinSync[1];
    wire sFrame = pinSync[0];

    // ============================================================
    // Decode helpers
    function slotAllowed;
        input [1:0] slot;
        input [2:0] rate;
        begin
            case (slot)
                `ADCPM_SLOT_512: slotAllowed = (rate == `ADCPM_FS_48K);
                `ADCPM_SLOT_256: slotAllowed = (rate == `ADCPM_FS_48K) || (rate == `ADCPM_FS_96K);
                `ADCPM_SLOT_128: slotAllowed = (rate <= `ADCPM_FS_192K);
                default: slotAllowed = 1'b1;
            endcase
        end
    endfunction

    function [PAIR_W-1:0] maskPair;
        input [PAIR_W-1:0] d;
        input wl32;
        begin
            maskPair = wl32 ? d : (d & {`ADCPM_MASK24, `ADCPM_MASK24});
        end
    endfunction

    // ============================================================
    // Strap decode
    reg bsMode;
    reg slotErr;
    reg cfgErr;
    reg [4:0] next_filter;
    reg [3:0] next_delay;

    always @* begin
        next_filter = `ADCPM_FLT_SHARP;
        next_delay = `ADCPM_GD_SHARP;
        if (rateClass == `ADCPM_FS_768K) begin
            next_filter = `ADCPM_FLT_SINGLE;
            next_delay = `ADCPM_GD_768K;
        end else if (rateClass == `ADCPM_FS_384K) begin
            next_filter = `ADCPM_FLT_SINGLE;
            next_delay = `ADCPM_GD_384K;
        end else if (sDelay) begin
            next_filter = sRolloff ? `ADCPM_FLT_SD_SLOW : `ADCPM_FLT_SD_SHARP;
            next_delay = `ADCPM_GD_SHORT;
        end else if (sRolloff) begin
            next_filter = `ADCPM_FLT_SLOW;
            next_delay = `ADCPM_GD_SLOW;
        end
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            bsMode <= 1'b0;
            pcmMode <= 1'b0;
            ctrlMode <= `ADCPM_CTRL_THREE;
            clockModeSel <= 4'h0;
            ctrlDataIn <= 1'b0;
            ctrlChipSelect <= 1'b0;
            ctrlShiftClock <= 1'b0;
            chipAddr <= 2'h0;
            slowRolloffSel <= 1'b0;
            bitClockPolaritySel <= 1'b0;
            shortDelaySel <= 1'b0;
            phaseModSel <= 1'b0;
            frameFormatSel <= 1'b0;
            wordLengthSel <= 1'b0;
            bitstreamRateSel <= 2'h0;
            bitstreamOsr <= `ADCPM_OSR_64;
            slotFormatActive <= `ADCPM_SLOT_NORMAL;
            slotErr <= 1'b0;
            cfgErr <= 1'b0;
            filterSel <= `ADCPM_FLT_SHARP;
            groupDelay <= `ADCPM_GD_SHARP;
        end else if (clkEn) begin
            bsMode <= sBs;
            pcmMode <= !sBs;
            if (!sBusSel) begin
                ctrlMode <= `ADCPM_CTRL_THREE;
            end else begin
                ctrlMode <= sPsn ? `ADCPM_CTRL_PAR : `ADCPM_CTRL_TWO;
            end
            clockModeSel <= (sBusSel && sPsn) ? sShared : 4'h0;
            ctrlDataIn <= !(sBusSel && sPsn) && sShared[0];
            ctrlChipSelect <= !sBusSel && sShared[1];
            ctrlShiftClock <= !(sBusSel && sPsn) && sShared[2];
            chipAddr[1] <= !(sBusSel && sPsn) && sShared[3];
            chipAddr[0] <= sBusSel ? (!sPsn && sShared[1]) : sPsn;
            slowRolloffSel <= !sBs && sRolloff;
            bitClockPolaritySel <= sBs && sRolloff;
            shortDelaySel <= !sBs && sDelay;
            phaseModSel <= sBs && sDelay;
            frameFormatSel <= !sBs && sFmt0;
            wordLengthSel <= !sBs && sFmt1;
            bitstreamRateSel <= sBs ? {sFmt1, sFmt0} : 2'h0;
            case ({sFmt1, sFmt0})
                `ADCPM_RATE_64: bitstreamOsr <= `ADCPM_OSR_64;
                `ADCPM_RATE_128: bitstreamOsr <= `ADCPM_OSR_128;
                default: bitstreamOsr <= `ADCPM_OSR_256;
            endcase
            cfgErr <= sBs && (sSlot != `ADCPM_SLOT_NORMAL);
            slotErr <= !slotAllowed(sSlot, rateClass);
            slotFormatActive <= (sBs || !slotAllowed(sSlot, rateClass)) ? `ADCPM_SLOT_NORMAL : sSlot;
            filterSel <= next_filter;
            groupDelay <= next_delay;
        end
    end

    // ============================================================
    // Link clock and frame edge detection
    reg bitClkPrev;
    reg framePrev;
    wire bitRise = sBitClk && !bitClkPrev;
    wire bitFall = !sBitClk && bitClkPrev;
    wire frameRise = sFrame && !framePrev;
    wire frameFall = !sFrame && framePrev;
    wire frameStart = !bsMode && (frameFormatSel ? frameFall : frameRise);
    wire updEdge = bsMode ? (bitClockPolaritySel ? bitRise : bitFall) : bitFall;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            bitClkPrev <= 1'b0;
            framePrev <= 1'b0;
        end else if (clkEn) begin
            bitClkPrev <= sBitClk;
            framePrev <= sFrame;
        end
    end

    // ============================================================
    // Frame bit counter and group delay sequencer
    reg [9:0] bitCnt;
    reg [1:0] state;
    reg [3:0] delayCnt;
    reg phaseBit;
    wire [9:0] frameBits = `ADCPM_PAIR_BITS << slotFormatActive;
    wire bsReload = bsMode && updEdge && (bitCnt[4:0] == `ADCPM_WORD_LAST);
    wire loadPair = frameStart || bsReload;
    wire popReq = loadPair && (state == ST_RUN);
    wire bufValid;
    wire [LANES*PAIR_W-1:0] bufData;
    wire popOk = popReq && bufValid;
    wire i2sLead = frameFormatSel && !bsMode;
    wire [9:0] dataIdx = bitCnt - {9'h000, i2sLead};
    wire pcmInPair = !(i2sLead && (bitCnt == 10'h000)) && (dataIdx < `ADCPM_PAIR_BITS);
    wire [5:0] pcmPos = `ADCPM_PAIR_TOP - dataIdx[5:0];
    wire [5:0] bsPosL = `ADCPM_PAIR_TOP - {1'b0, bitCnt[4:0]};
    wire [5:0] bsPosR = `ADCPM_WORD_TOP - {1'b0, bitCnt[4:0]};

    always @(posedge clk_sys) begin
        if (!rstn) begin
            bitCnt <= 10'h000;
            state <= ST_WAIT;
            delayCnt <= 4'h0;
            phaseBit <= 1'b0;
            running <= 1'b0;
        end else if (clkEn) begin
            if (frameStart) begin
                bitCnt <= 10'h000;
            end else if (updEdge) begin
                if (bsMode) begin
                    bitCnt <= {5'h00, bitCnt[4:0] + 5'h01};
                end else if (bitCnt < frameBits) begin
                    bitCnt <= bitCnt + 10'h001;
                end
            end
            if (updEdge) begin
                phaseBit <= phaseModSel && !phaseBit;
            end
            case (state)
                ST_WAIT: begin
                    if (bsMode) begin
                        state <= ST_RUN;
                    end else if (frameStart) begin
                        delayCnt <= delayCnt + 4'h1;
                        if (delayCnt + 4'h1 >= groupDelay) begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RUN: state <= ST_RUN;
                default: state <= ST_WAIT;
            endcase
            running <= (state == ST_RUN);
        end
    end

    // ============================================================
    // Sample buffer
    adcpm_buf #(.WIDTH(LANES * PAIR_W), .DEPTH(2), .AW(1)) uBuf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clkEn(clkEn),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(sampleData),
        .outValid(bufValid),
        .outReady(popReq),
        .outData(bufData)
    );

    // ============================================================
    // Per-lane serialisers
    wire [LANES-1:0] laneL;
    wire [LANES-1:0] laneR;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : gLane
            reg [PAIR_W-1:0] pair;
            reg leftBit;
            reg rightBit;
            wire tailBit = (g == 0) ? sCascade : 1'b0;
            assign laneL[g] = leftBit;
            assign laneR[g] = rightBit;
            always @(posedge clk_sys) begin
                if (!rstn) begin
                    pair <= {PAIR_W{1'b0}};
                    leftBit <= 1'b0;
                    rightBit <= 1'b0;
                end else if (clkEn) begin
                    if (loadPair) begin
                        pair <= popOk ? maskPair(bufData[g*PAIR_W +: PAIR_W], wordLengthSel | bsMode) : {PAIR_W{1'b0}};
                    end
                    if (updEdge) begin
                        if (bsMode) begin
                            leftBit <= pair[bsPosL] ^ phaseBit;
                            rightBit <= pair[bsPosR] ^ phaseBit;
                        end else begin
                            leftBit <= pcmInPair ? pair[pcmPos] : tailBit;
                            rightBit <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ============================================================
    // Output pins
    always @(posedge clk_sys) begin
        if (!rstn) begin
            pcmOut1 <= 1'b0;
            pcmOut2 <= 1'b0;
            pcmOut3 <= 1'b0;
            bsOutL1 <= 1'b0;
            bsOutR1 <= 1'b0;
            bsOutR1Oe <= 1'b0;
            bsOutR3 <= 1'b0;
            overflowFlagOut <= 1'b0;
            testOut1 <= 1'b0;
            testOut1Oe <= 1'b0;
            testOut2 <= 1'b0;
            testOut2Oe <= 1'b0;
        end else if (clkEn) begin
            pcmOut1 <= bsMode ? laneL[1] : laneL[0];
            pcmOut2 <= bsMode ? laneR[1] : laneL[1];
            pcmOut3 <= bsMode ? laneL[2] : laneL[2];
            bsOutL1 <= bsMode && laneL[0];
            bsOutR1 <= bsMode && laneR[0];
            bsOutR1Oe <= bsMode;
            bsOutR3 <= bsMode && laneR[2];
            overflowFlagOut <= sOvf;
            testOut1 <= cfgErr;
            testOut1Oe <= 1'b1;
            testOut2 <= slotErr;
            testOut2Oe <= 1'b1;
        end
    end
endmodule // adcpm_top

`default_nettype wire

// File: tb/adcpm_top_properties.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Strap decode and power-down checks
module adcpm_top_properties (
    input wire clk_sys,
    input wire rstn,
    input wire bitstreamModePin,
    input wire ctrlBusSelPin,
    input wire parallelOrTwowireSelect,
    input wire [3:0] sharedCtrlPin,
    input wire rolloffPolarityPin,
    input wire shortDelayPhasePin,
    input wire formatRatePin0,
    input wire formatRatePin1,
    input wire slotFormatSel0,
    input wire slotFormatSel1,
    input wire overflowIn,
    input wire [2:0] rateClass,
    input wire [2:0] ctrlMode,
    input wire [1:0] chipAddr,
    input wire pcmMode,
    input wire slowRolloffSel,
    input wire shortDelaySel,
    input wire bitClockPolaritySel,
    input wire phaseModSel,
    input wire frameFormatSel,
    input wire wordLengthSel,
    input wire [1:0] bitstreamRateSel,
    input wire [1:0] slotFormatActive,
    input wire [4:0] filterSel,
    input wire [3:0] groupDelay,
    input wire pcmOut1,
    input wire pcmOut2,
    input wire pcmOut3,
    input wire overflowFlagOut
);
    reg [2:0] upCnt;
    wire [18:0] pins = {bitstreamModePin, ctrlBusSelPin, parallelOrTwowireSelect, sharedCtrlPin, rolloffPolarityPin,
        shortDelayPhasePin, formatRatePin0, formatRatePin1, slotFormatSel0, slotFormatSel1, overflowIn, rateClass};
    wire pcmPins = !bitstreamModePin;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            upCnt <= 3'h0;
        end else if (upCnt != 3'h7) begin
            upCnt <= upCnt + 3'h1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // ============================================================
    // Straps held still long enough to pass the synchronisers
    sequence s_quiet;
        (upCnt == 3'h7 && $stable(pins)) [*4];
    endsequence

    property p_mode;
        s_quiet |-> pcmMode == pcmPins;
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    property p_ctrl;
        s_quiet |-> ctrlMode == (!ctrlBusSelPin ? 3'h1 : (parallelOrTwowireSelect ? 3'h4 : 3'h2));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control bus decode wrong");
    property p_addr;
        s_quiet ##0 !(ctrlBusSelPin && parallelOrTwowireSelect) |->
            chipAddr == {sharedCtrlPin[3], ctrlBusSelPin ? sharedCtrlPin[1] : parallelOrTwowireSelect};
    endproperty
    a_addr: assert property (p_addr) else $error("chip address wrong");
    property p_pcm;
        s_quiet ##0 pcmPins |-> {frameFormatSel, wordLengthSel, slowRolloffSel, shortDelaySel} ==
            {formatRatePin0, formatRatePin1, rolloffPolarityPin, shortDelayPhasePin};
    endproperty
    a_pcm: assert property (p_pcm) else $error("pcm pin roles wrong");
    property p_bs;
        s_quiet ##0 !pcmPins |-> {bitstreamRateSel, bitClockPolaritySel, phaseModSel} ==
            {formatRatePin1, formatRatePin0, rolloffPolarityPin, shortDelayPhasePin};
    endproperty
    a_bs: assert property (p_bs) else $error("stream pin roles wrong");
    property p_flt;
        s_quiet ##0 (pcmPins && rateClass < 3'h3) |-> filterSel == (5'h01 << {shortDelayPhasePin, rolloffPolarityPin})
            && groupDelay == (shortDelayPhasePin ? 4'h6 : (rolloffPolarityPin ? 4'h8 : 4'hf));
    endproperty
    a_flt: assert property (p_flt) else $error("filter select wrong");
    property p_fast;
        s_quiet ##0 (pcmPins && rateClass >= 3'h3) |-> filterSel == 5'h10 &&
            groupDelay == (rateClass == 3'h3 ? 4'h7 : 4'h5);
    endproperty
    a_fast: assert property (p_fast) else $error("high rate filter wrong");
    property p_slot;
        s_quiet |-> !(slotFormatActive == 2'h3 && rateClass != 3'h0) && !(slotFormatActive == 2'h2 && rateClass > 3'h1);
    endproperty
    a_slot: assert property (p_slot) else $error("slot format beyond rate");
    property p_pd;
        disable iff (1'b0) !rstn |=> !pcmOut1 && !pcmOut2 && !pcmOut3 && !overflowFlagOut;
    endproperty
    a_pd: assert property (p_pd) else $error("output not low in power-down");
    property p_ovf;
        s_quiet |-> overflowFlagOut == overflowIn;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
endmodule // adcpm_top_properties

`default_nettype wire

// File: tb/adcpm_dsp_model.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Serial receiver: makes bit and frame clocks, captures frames
module adcpm_dsp_model (
    input wire logic linkOn,
    input wire logic dataA,
    input wire logic dataC,
    output logic bitClk,
    output logic frameSync,
    output logic [63:0] frameA,
    output logic [63:0] frameC,
    output logic [7:0] frameCnt
);
    logic [63:0] shA;
    logic [63:0] shC;
    logic [5:0] bitCnt;

    initial begin
        bitClk = 1'b1;
        frameSync = 1'b0;
        {shA, shC, frameA, frameC, frameCnt} = '0;
        bitCnt = 6'h3f;
        #13;
        forever begin
            // Bit clock stands still while the link is off
            while (!linkOn) #100;
            #400;
            bitClk = 1'b0;
            bitCnt = bitCnt + 6'h1;
            // Frame clock moves on falls, high in the first half
            frameSync = (bitCnt < 6'h20);
            #400;
            bitClk = 1'b1;
            // Data changes after falls, so it is taken on rises
            shA = {shA[62:0], dataA};
            shC = {shC[62:0], dataC};
            if (bitCnt == 6'h0) begin
                frameA = shA;
                frameC = shC;
                frameCnt = frameCnt + 8'h1;
            end
        end
    end
endmodule // adcpm_dsp_model

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Bench: strap table, then sample path through the link
module tb;
    logic clk_sys, rstn, bitstreamModePin, ctrlBusSelPin, parallelOrTwowireSelect, rolloffPolarityPin;
    logic shortDelayPhasePin, formatRatePin0, formatRatePin1, slotFormatSel0, slotFormatSel1, overflowIn;
    logic sampleValid, linkOn;
    logic clkEn = 1'b1;
    logic cascadeSlotIn = 1'b0;
    logic [3:0] sharedCtrlPin;
    logic [2:0] rateClass;
    logic [191:0] sampleData;
    wire sampleReady, pcmMode, pcmOut1, pcmOut3, overflowFlagOut, bitClkIn, frameSyncIn;
    wire [2:0] ctrlMode;
    wire [1:0] chipAddr, slotFormatActive;
    wire [4:0] filterSel;
    wire [3:0] groupDelay;
    wire [8:0] bitstreamOsr;
    wire [63:0] frameA, frameC;
    wire [7:0] frameCnt;
    int error_cnt = 0;
    int checked = 0;
    int i, k, n, m;
    logic [15:0] pinRow [10];
    logic [25:0] expRow [10];
    logic [25:0] mask;
    logic [191:0] word [3];

    adcpm_top dut (.*, .ctrlDataIn(), .ctrlChipSelect(), .ctrlShiftClock(), .clockModeSel(), .slowRolloffSel(),
        .bitClockPolaritySel(), .shortDelaySel(), .phaseModSel(), .frameFormatSel(), .wordLengthSel(),
        .bitstreamRateSel(), .running(), .pcmOut2(), .bsOutL1(), .bsOutR1(), .bsOutR1Oe(), .bsOutR3(),
        .testOut1(), .testOut1Oe(), .testOut2(), .testOut2Oe());
    adcpm_dsp_model dsp (.linkOn(linkOn), .dataA(pcmOut1), .dataC(pcmOut3), .bitClk(bitClkIn),
        .frameSync(frameSyncIn), .frameA(frameA), .frameC(frameC), .frameCnt(frameCnt));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task chk(input string name, input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task summarize;
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask

    task limit(input int c);
        if (c >= 30000) begin
            error_cnt++;
            summarize;
        end
    endtask

    // Straps move only while held in power-down
    task strap(input logic [15:0] p);
        rstn = 1'b0;
        {bitstreamModePin, ctrlBusSelPin, parallelOrTwowireSelect, sharedCtrlPin, rolloffPolarityPin,
            shortDelayPhasePin, formatRatePin1, formatRatePin0, slotFormatSel1, slotFormatSel0, rateClass} = p;
        cyc(6);
        rstn = 1'b1;
        cyc(6);
    endtask

    task push(input logic [191:0] d);
        sampleData = d;
        sampleValid = 1'b1;
        for (n = 0; n < 30000 && sampleReady !== 1'b1; n++) cyc(1);
        limit(n);
        cyc(1);
    endtask

    task next_frame;
        m = frameCnt;
        for (n = 0; n < 30000 && frameCnt == m[7:0]; n++) cyc(1);
        limit(n);
    endtask

    initial begin
        {rstn, sampleValid, linkOn, overflowIn, sampleData} = '0;
        strap(16'h0);
        pinRow = '{{3'h1, 4'h8, 2'h0, 2'h2, 2'h0, 3'h0}, {3'h2, 4'h2, 2'h2, 2'h0, 2'h1, 3'h0},
            {3'h3, 4'h5, 2'h1, 2'h0, 2'h3, 3'h1}, {3'h0, 4'h0, 2'h3, 2'h1, 2'h2, 3'h1},
            {3'h2, 4'ha, 2'h3, 2'h0, 2'h0, 3'h3}, {3'h1, 4'h0, 2'h0, 2'h0, 2'h0, 3'h4},
            {3'h0, 4'h8, 2'h2, 2'h0, 2'h2, 3'h2}, {3'h4, 4'h0, 2'h0, 2'h0, 2'h0, 3'h0},
            {3'h6, 4'h2, 2'h0, 2'h1, 2'h0, 3'h0}, {3'h4, 4'h8, 2'h0, 2'h2, 2'h0, 3'h0}};
        expRow = '{{4'h9, 2'h3, 5'h01, 4'hf, 2'h0, 9'h0}, {4'ha, 2'h1, 5'h02, 4'h8, 2'h1, 9'h0},
            {4'hc, 2'h0, 5'h04, 4'h6, 2'h0, 9'h0}, {4'h9, 2'h0, 5'h08, 4'h6, 2'h2, 9'h0},
            {4'ha, 2'h3, 5'h10, 4'h7, 2'h0, 9'h0}, {4'h9, 2'h1, 5'h10, 4'h5, 2'h0, 9'h0},
            {4'h9, 2'h2, 5'h02, 4'h8, 2'h0, 9'h0}, {4'h1, 2'h0, 5'h00, 4'h0, 2'h0, 9'h040},
            {4'h2, 2'h1, 5'h00, 4'h0, 2'h0, 9'h080}, {4'h1, 2'h2, 5'h00, 4'h0, 2'h0, 9'h100}};
        for (i = 0; i < 10; i++) begin
            strap(pinRow[i]);
            mask = bitstreamModePin ? 26'h3f007ff : 26'h3fffe00;
            if (ctrlBusSelPin && parallelOrTwowireSelect) mask = mask & 26'h3cfffff;
            chk("decode", {pcmMode, ctrlMode, chipAddr, filterSel, groupDelay, slotFormatActive, bitstreamOsr} & mask,
                expRow[i] & mask);
        end
        // PCM, 32-bit MSB-justified, short delay sharp, then fill the buffer with the link stalled
        strap({3'h3, 4'h0, 2'h1, 2'h2, 2'h0, 3'h0});
        for (i = 0; i < 3; i++) word[i] = {64'h8123_4567_0000_00a0 + i, 64'h5a5a_0f0f_3c3c_c3c3, 64'hc0de_0001_f00d_0010 + i};
        push(word[0]);
        push(word[1]);
        sampleData = word[2];
        cyc(2);
        chk("sampleReady", sampleReady, 1'b0);
        linkOn = 1'b1;
        push(word[2]);
        sampleValid = 1'b0;
        for (i = 0; i < 20 && frameA == 64'h0; i++) next_frame;
        // One capture precedes the first full zero frame, then six zero frames
        chk("delay", frameCnt >= 8'h8 && frameCnt <= 8'h9, 1'b1);
        for (k = 0; k < 3; k++) begin
            chk("lane0", frameA, word[k][63:0]);
            chk("lane2", frameC, word[k][191:128]);
            if (k < 2) next_frame;
        end
        overflowIn = 1'b1;
        cyc(5);
        chk("overflow", overflowFlagOut, 1'b1);
        rstn = 1'b0;
        cyc(1);
        chk("powerdown", {overflowFlagOut, pcmOut1, pcmOut3}, 3'h0);
        summarize;
    end
endmodule // tb

bind adcpm_top adcpm_top_properties chk (.*);

`default_nettype wire
